// ### core/pios_output_select.sv
`timescale 1ns/1ns
`default_nettype none
module pios_output_select (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register writes
  input wire logic value_write,
  input wire logic select_write,
  input wire logic select_set_write,
  input wire logic [pios_pkg::DATA_W-1:0] wdata,
  // dead-time generator outputs
  input wire logic [pios_pkg::CH_N-1:0] deadtime_high_out,
  input wire logic [pios_pkg::CH_N-1:0] deadtime_low_out,
  // register contents
  output logic [pios_pkg::CH_N-1:0] high_override_value,
  output logic [pios_pkg::CH_N-1:0] low_override_value,
  output logic [pios_pkg::CH_N-1:0] high_output_select,
  output logic [pios_pkg::CH_N-1:0] low_output_select,
  // channel outputs
  output logic [pios_pkg::CH_N-1:0] channel_high_output,
  output logic [pios_pkg::CH_N-1:0] channel_low_output
);

  logic [pios_pkg::CH_N-1:0] w_high;
  logic [pios_pkg::CH_N-1:0] w_low;
  logic [pios_pkg::CH_N-1:0] hsel_d;
  logic [pios_pkg::CH_N-1:0] lsel_d;
  logic [pios_pkg::CH_N-1:0] hout_d;
  logic [pios_pkg::CH_N-1:0] lout_d;

  // field extraction from the written word
  assign w_high = wdata[pios_pkg::HIGH_LSB +: pios_pkg::CH_N];
  assign w_low = wdata[pios_pkg::LOW_LSB +: pios_pkg::CH_N];

  // direct write replaces, set write only ever adds override choices
  assign hsel_d = select_write ? w_high : // R14
                  select_set_write ? (high_output_select | w_high) : high_output_select;
  assign lsel_d = select_write ? w_low : // R15
                  select_set_write ? (low_output_select | w_low) : low_output_select;

  // per-bit choice between dead-time output and override value
  assign hout_d = (high_output_select & high_override_value) | // R12
                  (~high_output_select & deadtime_high_out);
  assign lout_d = (low_output_select & low_override_value) | // R13
                  (~low_output_select & deadtime_low_out);

  // outputs are registered so pins never glitch while a select changes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      high_override_value <= pios_pkg::CH_RESET;
      low_override_value <= pios_pkg::CH_RESET;
      high_output_select <= pios_pkg::CH_RESET;
      low_output_select <= pios_pkg::CH_RESET;
      channel_high_output <= pios_pkg::CH_RESET;
      channel_low_output <= pios_pkg::CH_RESET;
    end else begin
      if (value_write) begin
        high_override_value <= w_high; // R11
        low_override_value <= w_low; // R11
      end
      high_output_select <= hsel_d;
      low_output_select <= lsel_d;
      channel_high_output <= hout_d;
      channel_low_output <= lout_d;
    end
  end

  select_mux_a: assert property (@(posedge core_clk) disable iff (!resetn) // R12
    channel_high_output == $past(hout_d) && channel_low_output == $past(lout_d))
    else $error("channel output does not follow selection");

  select_set_a: assert property (@(posedge core_clk) disable iff (!resetn) // R14
    select_set_write |=> (high_output_select == ($past(high_output_select) | $past(w_high)))
    && (low_output_select == ($past(low_output_select) | $past(w_low))))
    else $error("selection set write gave wrong select bits");

endmodule
`default_nettype wire

// ### core/pios_pkg.sv
// shared constants for the second interrupt group and output override selection
package pios_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_IRQ2_ENABLE = 8'h00;
  localparam logic [7:0] OFF_IRQ2_DISABLE = 8'h04;
  localparam logic [7:0] OFF_IRQ2_MASK = 8'h08;
  localparam logic [7:0] OFF_IRQ2_STATUS = 8'h0c;
  localparam logic [7:0] OFF_OVERRIDE_VALUE = 8'h10;
  localparam logic [7:0] OFF_OUTPUT_SELECT = 8'h14;
  localparam logic [7:0] OFF_OUTPUT_SELECT_SET = 8'h18;
  localparam logic [7:0] OFF_SYNC_CONFIG = 8'h1c;

  // interrupt word layout
  localparam int MISC_N = 4;
  localparam int CMP_N = 8;
  localparam int CMPM_LSB = 8;
  localparam int CMPU_LSB = 16;

  // packed internal layout: misc[3:0], match[11:4], update[19:12]
  localparam int IRQ_W = MISC_N + 2 * CMP_N;
  localparam int IV_CMPM = MISC_N;
  localparam int IV_CMPU = MISC_N + CMP_N;
  localparam int SYNC_WRITE_READY_BIT = 0;
  localparam int DMA_TRANSFER_END_BIT = 1;
  localparam int BUFE_BIT = 2;
  localparam int SYNC_UPDATE_UNDERRUN_BIT = 3;

  // sticky flags: every interrupt bit except the buffer empty level
  localparam int ST_W = IRQ_W - 1;

  // channel override layout
  localparam int CH_N = 4;
  localparam int HIGH_LSB = 0;
  localparam int LOW_LSB = 16;

  // sync update mode field and codes
  localparam int MODE_W = 2;
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_AUTO_DMA = 2'h2;

  // reset values
  localparam logic [IRQ_W-1:0] MASK_RESET = 20'h00000;
  localparam logic [CH_N-1:0] CH_RESET = 4'h0;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

  // bus word to internal interrupt vector
  function automatic logic [IRQ_W-1:0] unpack_irq(input logic [DATA_W-1:0] w);
    unpack_irq = {w[CMPU_LSB +: CMP_N], w[CMPM_LSB +: CMP_N], w[MISC_N-1:0]};
  endfunction

  // internal interrupt vector to bus word, unused bits zero
  function automatic logic [DATA_W-1:0] pack_irq(input logic [IRQ_W-1:0] v);
    pack_irq = ZERO_WORD;
    pack_irq[MISC_N-1:0] = v[MISC_N-1:0];
    pack_irq[CMPM_LSB +: CMP_N] = v[IV_CMPM +: CMP_N];
    pack_irq[CMPU_LSB +: CMP_N] = v[IV_CMPU +: CMP_N];
  endfunction

  // high and low channel fields to bus word
  function automatic logic [DATA_W-1:0] pack_ch(input logic [CH_N-1:0] hi,
                                                input logic [CH_N-1:0] lo);
    pack_ch = ZERO_WORD;
    pack_ch[HIGH_LSB +: CH_N] = hi;
    pack_ch[LOW_LSB +: CH_N] = lo;
  endfunction

endpackage

// ### core/pios_sticky_flags.sv
`timescale 1ns/1ns
`default_nettype none
module pios_sticky_flags (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // per-flag set and clear
  input wire logic [pios_pkg::ST_W-1:0] set_vec,
  input wire logic [pios_pkg::ST_W-1:0] clr_vec,
  // held flags
  output logic [pios_pkg::ST_W-1:0] flags_q
);

  logic [pios_pkg::ST_W-1:0] flags_d;

  // set wins over a clear in the same cycle so no event is lost
  assign flags_d = set_vec | (flags_q & ~clr_vec); // R7 R8 R9

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  sticky_set_a: assert property (@(posedge core_clk) disable iff (!resetn) // R8
    (set_vec != '0) |=> ((flags_q & $past(set_vec)) == $past(set_vec)))
    else $error("event flag not held after its event");

  sticky_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // R7
    (clr_vec == '0) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("flag dropped without a clear");

endmodule
`default_nettype wire

// ### core/pios_top.sv
// Summary of operation
// [R1] write-only enable register, fixed bit layout
// [R2] write-only disable register, same layout
// [R3] read-only mask shows enabled sources
// [R4] write ready flag means sync values writable
// [R5] transfer end once counter hit zero
// [R6] buffer empty when both counters zero
// [R7] underrun flag sticky until status read
// [R8] eight sticky compare match flags, bits 8-15
// [R9] eight sticky compare update flags, bits 16-23
// [R10] status read clears sticky flags; transfer end is cleared by dma_program instead
// [R11] readable writable override values per channel
// [R12] high select picks dead-time or override
// [R13] low select picks dead-time or override
// [R14] set register ones set high selects
// [R15] set register ones set low selects
// [R16] write ready set on period, never manual
// [R17] enable ones set, disable ones clear mask
// [R18] interrupt when flag and mask both set
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
module pios_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [pios_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pios_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [pios_pkg::DATA_W-1:0] reg_rdata,
  // sync channel events, same clock
  input wire logic sync_period_elapsed,
  input wire logic sync_underrun_event,
  // comparison events, same clock
  input wire logic [pios_pkg::CMP_N-1:0] compare_match_event,
  input wire logic [pios_pkg::CMP_N-1:0] compare_update_event,
  // peripheral dma state, same clock
  input wire logic dma_program,
  input wire logic [15:0] transmit_counter,
  input wire logic [15:0] next_transmit_counter,
  // dead-time generator outputs
  input wire logic [pios_pkg::CH_N-1:0] deadtime_high_out,
  input wire logic [pios_pkg::CH_N-1:0] deadtime_low_out,
  // channel outputs
  output logic [pios_pkg::CH_N-1:0] channel_high_output,
  output logic [pios_pkg::CH_N-1:0] channel_low_output,
  // configuration and interrupt
  output logic [pios_pkg::MODE_W-1:0] sync_update_mode,
  output logic irq_request
);

  // address decode
  logic hit_enable;
  logic hit_disable;
  logic hit_mask;
  logic hit_status;
  logic hit_value;
  logic hit_select;
  logic hit_select_set;
  logic hit_config;
  logic wr_enable;
  logic wr_disable;
  logic wr_value;
  logic wr_select;
  logic wr_select_set;
  logic wr_config;
  logic rd_status;

  assign hit_enable = reg_addr == pios_pkg::OFF_IRQ2_ENABLE;
  assign hit_disable = reg_addr == pios_pkg::OFF_IRQ2_DISABLE;
  assign hit_mask = reg_addr == pios_pkg::OFF_IRQ2_MASK;
  assign hit_status = reg_addr == pios_pkg::OFF_IRQ2_STATUS;
  assign hit_value = reg_addr == pios_pkg::OFF_OVERRIDE_VALUE;
  assign hit_select = reg_addr == pios_pkg::OFF_OUTPUT_SELECT;
  assign hit_select_set = reg_addr == pios_pkg::OFF_OUTPUT_SELECT_SET;
  assign hit_config = reg_addr == pios_pkg::OFF_SYNC_CONFIG;

  // qualified strobes
  assign wr_enable = reg_write & hit_enable;
  assign wr_disable = reg_write & hit_disable;
  assign wr_value = reg_write & hit_value;
  assign wr_select = reg_write & hit_select;
  assign wr_select_set = reg_write & hit_select_set;
  assign wr_config = reg_write & hit_config;
  assign rd_status = reg_read & hit_status;

  // interrupt mask
  logic [pios_pkg::IRQ_W-1:0] mask_q;
  logic [pios_pkg::IRQ_W-1:0] mask_d;
  logic [pios_pkg::IRQ_W-1:0] en_bits;
  logic [pios_pkg::IRQ_W-1:0] dis_bits;

  // only written ones act; enable and disable never share a cycle
  assign en_bits = wr_enable ? pios_pkg::unpack_irq(reg_wdata) : '0; // R1
  assign dis_bits = wr_disable ? pios_pkg::unpack_irq(reg_wdata) : '0; // R2
  assign mask_d = (mask_q | en_bits) & ~dis_bits; // R17

  // sync update mode, steers the write ready flag
  logic [pios_pkg::MODE_W-1:0] mode_q;
  logic [pios_pkg::MODE_W-1:0] mode_d;
  logic auto_mode;

  assign mode_d = wr_config ? reg_wdata[pios_pkg::MODE_LSB +: pios_pkg::MODE_W] : mode_q;
  // the reserved code behaves like manual, so no flag is ever raised by it
  assign auto_mode = (mode_q == pios_pkg::MODE_AUTO) || (mode_q == pios_pkg::MODE_AUTO_DMA);
  assign sync_update_mode = mode_q;

  // event sources
  logic sync_write_ready_set;
  logic dma_transfer_end_set;
  logic bufe_now;

  assign sync_write_ready_set = auto_mode & sync_period_elapsed; // R16
  // counter at zero marks the end of the programmed transfer
  assign dma_transfer_end_set = transmit_counter == 16'h0000; // R5
  // level, not sticky: follows the two counters directly
  assign bufe_now = (transmit_counter == 16'h0000) && // R6
                    (next_transmit_counter == 16'h0000);

  // sticky flag set and clear vectors, order {update, match, sync_update_underrun, dma_transfer_end, sync_write_ready}
  logic [pios_pkg::ST_W-1:0] st_set;
  logic [pios_pkg::ST_W-1:0] st_clr;
  logic [pios_pkg::ST_W-1:0] st_flags;

  assign st_set = {compare_update_event, compare_match_event, // R8 R9
                   sync_underrun_event, dma_transfer_end_set, sync_write_ready_set}; // R7 R4
  // status read clears all but transfer end, which only reprogramming clears
  assign st_clr = {{(2 * pios_pkg::CMP_N){rd_status}}, rd_status, // R10
                   dma_program, rd_status};

  pios_sticky_flags u_flags (
    .core_clk(core_clk),
    .resetn(resetn),
    .set_vec(st_set),
    .clr_vec(st_clr),
    .flags_q(st_flags)
  );

  // full interrupt status in internal layout
  logic [pios_pkg::IRQ_W-1:0] status_vec;

  assign status_vec = {st_flags[pios_pkg::ST_W-1:pios_pkg::BUFE_BIT], bufe_now,
                       st_flags[pios_pkg::BUFE_BIT-1:0]};

  // output override and selection
  logic [pios_pkg::CH_N-1:0] hov;
  logic [pios_pkg::CH_N-1:0] lov;
  logic [pios_pkg::CH_N-1:0] hsel;
  logic [pios_pkg::CH_N-1:0] lsel;

  pios_output_select u_outsel (
    .core_clk(core_clk),
    .resetn(resetn),
    .value_write(wr_value),
    .select_write(wr_select),
    .select_set_write(wr_select_set),
    .wdata(reg_wdata),
    .deadtime_high_out(deadtime_high_out),
    .deadtime_low_out(deadtime_low_out),
    .high_override_value(hov),
    .low_override_value(lov),
    .high_output_select(hsel),
    .low_output_select(lsel),
    .channel_high_output(channel_high_output),
    .channel_low_output(channel_low_output)
  );

  // read mux; write-only and unmapped offsets read as zero
  logic [pios_pkg::DATA_W-1:0] rd_word;
  logic [pios_pkg::DATA_W-1:0] rdata_d;

  assign rd_word = hit_mask ? pios_pkg::pack_irq(mask_q) : // R3
                   hit_status ? pios_pkg::pack_irq(status_vec) :
                   hit_value ? pios_pkg::pack_ch(hov, lov) : // R11
                   hit_select ? pios_pkg::pack_ch(hsel, lsel) :
                   hit_config ? {{(pios_pkg::DATA_W - pios_pkg::MODE_W){1'b0}}, mode_q} :
                   pios_pkg::ZERO_WORD;
  // data stands for one cycle only, zero otherwise
  assign rdata_d = reg_read ? rd_word : pios_pkg::ZERO_WORD;

  // interrupt request, registered to keep the line glitch free
  logic irq_d;

  assign irq_d = |(status_vec & mask_q); // R18

  // state registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= pios_pkg::MASK_RESET;
      mode_q <= pios_pkg::MODE_MANUAL;
      reg_rdata <= pios_pkg::ZERO_WORD;
      irq_request <= 1'b0;
    end else begin
      mask_q <= mask_d;
      mode_q <= mode_d;
      reg_rdata <= rdata_d;
      irq_request <= irq_d;
    end
  end

  // checks on mask handling
  mask_set_a: assert property (@(posedge core_clk) disable iff (!resetn) // R17
    wr_enable |=> ((mask_q & $past(en_bits)) == $past(en_bits)))
    else $error("enable write did not set mask bits");

  mask_clear_a: assert property (@(posedge core_clk) disable iff (!resetn) // R2
    wr_disable |=> ((mask_q & $past(dis_bits)) == '0))
    else $error("disable write did not clear mask bits");

  mask_keep_a: assert property (@(posedge core_clk) disable iff (!resetn) // R1
    !(wr_enable || wr_disable) |=> $stable(mask_q))
    else $error("mask changed without an enable or disable write");

  mask_read_a: assert property (@(posedge core_clk) disable iff (!resetn) // R3
    (reg_read && hit_mask) |=> (reg_rdata == pios_pkg::pack_irq($past(mask_q))))
    else $error("mask read returned wrong value");

  // checks on status flags
  sync_write_ready_manual_a: assert property (@(posedge core_clk) disable iff (!resetn) // R16
    !auto_mode |=> (status_vec[pios_pkg::SYNC_WRITE_READY_BIT] <= $past(status_vec[pios_pkg::SYNC_WRITE_READY_BIT])))
    else $error("write ready rose outside an automatic mode");

  sync_write_ready_period_a: assert property (@(posedge core_clk) disable iff (!resetn) // R4
    (auto_mode && sync_period_elapsed) |=> status_vec[pios_pkg::SYNC_WRITE_READY_BIT])
    else $error("write ready not set after update period");

  dma_transfer_end_zero_a: assert property (@(posedge core_clk) disable iff (!resetn) // R5
    (transmit_counter == 16'h0000) |=> status_vec[pios_pkg::DMA_TRANSFER_END_BIT])
    else $error("transfer end not set at zero count");

  dma_transfer_end_prog_a: assert property (@(posedge core_clk) disable iff (!resetn) // R5
    (dma_program && transmit_counter != 16'h0000) |=> !status_vec[pios_pkg::DMA_TRANSFER_END_BIT])
    else $error("transfer end not cleared by reprogramming");

  bufe_level_a: assert property (@(posedge core_clk) disable iff (!resetn) // R6
    status_vec[pios_pkg::BUFE_BIT] ==
      ((transmit_counter == 16'h0000) && (next_transmit_counter == 16'h0000)))
    else $error("buffer empty does not match counters");

  read_clear_a: assert property (@(posedge core_clk) disable iff (!resetn) // R10
    (rd_status && !sync_underrun_event && compare_match_event == '0 &&
     compare_update_event == '0 && !sync_write_ready_set) |=>
    (status_vec[pios_pkg::SYNC_UPDATE_UNDERRUN_BIT] == 1'b0 && status_vec[pios_pkg::SYNC_WRITE_READY_BIT] == 1'b0 &&
     status_vec[pios_pkg::IRQ_W-1:pios_pkg::IV_CMPM] == '0))
    else $error("status read left flags set");

  status_read_a: assert property (@(posedge core_clk) disable iff (!resetn) // R8
    rd_status |=> (reg_rdata == pios_pkg::pack_irq($past(status_vec))))
    else $error("status read returned wrong value");

  irq_level_a: assert property (@(posedge core_clk) disable iff (!resetn) // R18
    irq_request == |($past(status_vec) & $past(mask_q)))
    else $error("interrupt request does not match flags and mask");

  override_rd_a: assert property (@(posedge core_clk) disable iff (!resetn) // R11
    wr_value |=>
    (pios_pkg::pack_ch(hov, lov) == ($past(reg_wdata) & pios_pkg::pack_ch('1, '1))))
    else $error("override value read back differs from written");

endmodule
`default_nettype wire

// ### test/pios_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
// compare two values, count the comparison and any mismatch
`define CHK(g, e) check_val(g, e)
module pios_top_tb;
  localparam logic [31:0] IRQ_BITS = 32'h00ffff0f;
  localparam logic [31:0] CH_BITS = 32'h000f000f;
  localparam logic [7:0] OFF_CFG = pios_pkg::OFF_SYNC_CONFIG;
  logic core_clk;
  logic resetn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_rdata;
  logic sync_period_elapsed;
  logic sync_underrun_event;
  logic [7:0] compare_match_event;
  logic [7:0] compare_update_event;
  logic dma_program;
  logic [15:0] transmit_counter;
  logic [15:0] next_transmit_counter;
  logic [3:0] deadtime_high_out;
  logic [3:0] deadtime_low_out;
  logic [3:0] channel_high_output;
  logic [3:0] channel_low_output;
  logic [1:0] sync_update_mode;
  logic irq_request;
  int num_errors;
  int comparisons;
  logic [31:0] lfsr_q;
  logic [31:0] rd;
  logic [31:0] w;
  logic [31:0] t;
  logic [31:0] exp_mask;
  logic [31:0] sel;
  logic [31:0] ov;

  pios_top i_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sync_period_elapsed(sync_period_elapsed), .sync_underrun_event(sync_underrun_event),
    .compare_match_event(compare_match_event), .compare_update_event(compare_update_event),
    .dma_program(dma_program), .transmit_counter(transmit_counter),
    .next_transmit_counter(next_transmit_counter), .deadtime_high_out(deadtime_high_out),
    .deadtime_low_out(deadtime_low_out), .channel_high_output(channel_high_output),
    .channel_low_output(channel_low_output), .sync_update_mode(sync_update_mode),
    .irq_request(irq_request)
  );

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // fixed-seed shift register keeps every run identical
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    lfsr_next = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic next_rand(output logic [31:0] r);
    lfsr_q = lfsr_next(lfsr_q);
    r = lfsr_q;
  endtask

  // expected channel output: override where selected, dead-time elsewhere
  function automatic logic [3:0] exp_out(input logic [3:0] s, input logic [3:0] o,
                                         input logic [3:0] d);
    exp_out = (s & o) | (~s & d);
  endfunction

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample right there
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    r = reg_rdata;
  endtask

  // one-cycle event pulses
  task automatic ev(input logic [7:0] m, input logic [7:0] u, input logic unr,
                    input logic per);
    @(posedge core_clk);
    compare_match_event <= m;
    compare_update_event <= u;
    sync_underrun_event <= unr;
    sync_period_elapsed <= per;
    @(posedge core_clk);
    compare_match_event <= 8'h00;
    compare_update_event <= 8'h00;
    sync_underrun_event <= 1'b0;
    sync_period_elapsed <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog sized well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    num_errors = 0;
    comparisons = 0;
    lfsr_q = 32'h97871cb6;
    exp_mask = 32'h00000000;
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    sync_period_elapsed = 1'b0;
    sync_underrun_event = 1'b0;
    compare_match_event = 8'h00;
    compare_update_event = 8'h00;
    dma_program = 1'b0;
    transmit_counter = 16'h0010;
    next_transmit_counter = 16'h0010;
    deadtime_high_out = 4'h0;
    deadtime_low_out = 4'h0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    // every register and two unmapped places read zero after reset
    for (int a = 0; a <= 8'h24; a += 4) begin
      reg_rd(a[7:0], rd);
      `CHK(rd, 32'h00000000);
    end
    // mask follows enable ones and disable ones, zeros leave it alone
    reg_wr(pios_pkg::OFF_IRQ2_ENABLE, 32'hffffffff);
    reg_wr(pios_pkg::OFF_IRQ2_MASK, 32'h00000000);
    reg_rd(pios_pkg::OFF_IRQ2_MASK, rd);
    `CHK(rd, IRQ_BITS);
    reg_wr(pios_pkg::OFF_IRQ2_DISABLE, 32'hffffffff);
    reg_rd(pios_pkg::OFF_IRQ2_MASK, rd);
    `CHK(rd, 32'h00000000);
    repeat (8) begin
      next_rand(w);
      reg_wr(pios_pkg::OFF_IRQ2_ENABLE, w);
      exp_mask = exp_mask | (w & IRQ_BITS);
      reg_rd(pios_pkg::OFF_IRQ2_MASK, rd);
      `CHK(rd, exp_mask);
      next_rand(w);
      reg_wr(pios_pkg::OFF_IRQ2_DISABLE, w);
      exp_mask = exp_mask & ~w;
      reg_rd(pios_pkg::OFF_IRQ2_MASK, rd);
      `CHK(rd, exp_mask);
    end
    // override values, selection, selection set and the output mux
    repeat (10) begin
      next_rand(ov);
      reg_wr(pios_pkg::OFF_OVERRIDE_VALUE, ov);
      reg_rd(pios_pkg::OFF_OVERRIDE_VALUE, rd);
      `CHK(rd, ov & CH_BITS);
      next_rand(w);
      reg_wr(pios_pkg::OFF_OUTPUT_SELECT, w);
      next_rand(t);
      reg_wr(pios_pkg::OFF_OUTPUT_SELECT_SET, t);
      sel = (w | t) & CH_BITS;
      reg_rd(pios_pkg::OFF_OUTPUT_SELECT, rd);
      `CHK(rd, sel);
      next_rand(w);
      @(posedge core_clk);
      deadtime_high_out <= w[3:0];
      deadtime_low_out <= w[7:4];
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(channel_high_output, exp_out(sel[3:0], ov[3:0], w[3:0]));
      `CHK(channel_low_output, exp_out(sel[19:16], ov[19:16], w[7:4]));
    end
    // sticky flags hold until a status read clears them
    repeat (6) begin
      next_rand(w);
      ev(w[15:8], w[23:16], w[3], 1'b0);
      reg_rd(pios_pkg::OFF_IRQ2_STATUS, rd);
      `CHK(rd, w & 32'h00ffff08);
      reg_rd(pios_pkg::OFF_IRQ2_STATUS, rd);
      `CHK(rd, 32'h00000000);
    end
    // write ready only in the automatic update modes
    for (int m = 0; m < 4; m++) begin
      reg_wr(OFF_CFG, m);
      #1;
      `CHK(sync_update_mode, m[1:0]);
      ev(8'h00, 8'h00, 1'b0, 1'b1);
      reg_rd(pios_pkg::OFF_IRQ2_STATUS, rd);
      `CHK(rd, (m == 1 || m == 2) ? 32'h00000001 : 32'h00000000);
      reg_rd(pios_pkg::OFF_IRQ2_STATUS, rd);
      `CHK(rd, 32'h00000000);
    end
    // transfer end sticks through reads, buffer empty is a live level
    @(posedge core_clk);
    transmit_counter <= 16'h0000;
    next_transmit_counter <= 16'h0005;
    repeat (2) @(posedge core_clk);
    reg_rd(pios_pkg::OFF_IRQ2_STATUS, rd);
    `CHK(rd, 32'h00000002);
    @(posedge core_clk);
    next_transmit_counter <= 16'h0000;
    repeat (2) @(posedge core_clk);
    reg_rd(pios_pkg::OFF_IRQ2_STATUS, rd);
    `CHK(rd, 32'h00000006);
    @(posedge core_clk);
    transmit_counter <= 16'h0003;
    next_transmit_counter <= 16'h0007;
    dma_program <= 1'b1;
    @(posedge core_clk);
    dma_program <= 1'b0;
    repeat (2) @(posedge core_clk);
    reg_rd(pios_pkg::OFF_IRQ2_STATUS, rd);
    `CHK(rd, 32'h00000000);
    // interrupt only for a flag whose mask bit is set
    reg_wr(pios_pkg::OFF_IRQ2_DISABLE, 32'hffffffff);
    reg_wr(pios_pkg::OFF_IRQ2_ENABLE, 32'h00000400);
    ev(8'h08, 8'h00, 1'b0, 1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(irq_request, 1'b0);
    ev(8'h04, 8'h00, 1'b0, 1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(irq_request, 1'b1);
    reg_rd(pios_pkg::OFF_IRQ2_STATUS, rd);
    `CHK(rd, 32'h00000c00);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(irq_request, 1'b0);
    print_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
